// [ecc_consts.svh]
// constants for the enhanced capture unit control block: offsets, fields, codes
// assumes 12-bit register addresses and 8-bit register data
`ifndef ECC_CONSTS_SVH
`define ECC_CONSTS_SVH

// ============================================================
// register offsets
`define ECC_UNIT1_CONTROL   12'hfba
`define ECC_UNIT2_CONTROL   12'hfb4
`define ECC_UNIT3_CONTROL   12'hf15
`define ECC_TIMER_SELECT    12'hf52
`define ECC_UNIT1_VAL_LOW   12'hf60
`define ECC_UNIT1_VAL_HIGH  12'hf61
`define ECC_UNIT2_VAL_LOW   12'hf62
`define ECC_UNIT2_VAL_HIGH  12'hf63
`define ECC_UNIT3_VAL_LOW   12'hf64
`define ECC_UNIT3_VAL_HIGH  12'hf65
`define ECC_IRQ_FLAGS       12'hf66

// ============================================================
// reset values
`define ECC_CONTROL_RESET   8'h00
`define ECC_TSEL_RESET      8'h00

// ============================================================
// mode field codes
`define ECC_MODE_OFF        4'h0
`define ECC_MODE_TOGGLE     4'h2
`define ECC_MODE_CAP_BOTH   4'h3
`define ECC_MODE_CAP_FALL   4'h4
`define ECC_MODE_CAP_RISE   4'h5
`define ECC_MODE_CAP_4TH    4'h6
`define ECC_MODE_CAP_16TH   4'h7
`define ECC_MODE_CMP_SET    4'h8
`define ECC_MODE_CMP_CLEAR  4'h9
`define ECC_MODE_CMP_SWI    4'ha
`define ECC_MODE_CMP_SPECIAL 4'hb
`define ECC_MODE_PWM_TOP    2'h3

// ============================================================
// output configuration codes
`define ECC_CFG_SINGLE      2'h0
`define ECC_CFG_FORWARD     2'h1
`define ECC_CFG_HALF        2'h2
`define ECC_CFG_REVERSE     2'h3

// ============================================================
// prescaler terminal counts
`define ECC_PRESC_4TH       2'h3
`define ECC_PRESC_16TH      4'hf

`endif

// [ecc_ctrl.sv]
// three enhanced capture/compare/pwm unit controls with shared timer selection
// assumes synchronous timer counts and a one-cycle strobe register port
// assumes software clears a flag by writing a one to its bit
`timescale 1ns/100ps
`include "ecc_consts.svh"

module ecc_ctrl
    import ecc_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              rst_i,
    input  wire logic [11:0]       addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic [7:0]             rdata_o,
    input  wire logic [2:0]        cap_pin_i,
    input  wire ecc_timers_t       timers_i,
    output logic [2:0][3:0]        pwm_out_o,
    output logic [2:0][3:0]        pwm_oe_o,
    output logic [2:0]             unit_irq_flag_o,
    output logic                   timer_one_reset_o,
    output logic                   timer_three_reset_o,
    output logic                   adc_start_o
);

    // ============================================================
    // helpers
    // reserved codes 1xx fall back to the first timer pair
    function automatic logic [1:0] timer_code(input logic [7:0] tsel, input int idx);
        logic [2:0] c;
        c = 3'h0;
        case (idx)
            0: c = tsel[2:0];
            1: c = tsel[5:3];
            default: c = {1'b0, tsel[7:6]};
        endcase
        timer_code = c[2] ? 2'h0 : c[1:0];
    endfunction

    function automatic logic [15:0] count16(input logic [1:0] code, input ecc_timers_t t);
        count16 = (code == 2'h0) ? t.timer_one_count : t.timer_three_count;
    endfunction

    function automatic logic [7:0] count8(input logic [1:0] code, input ecc_timers_t t);
        case (code)
            2'h0: count8 = t.t2;
            2'h1: count8 = t.t4;
            2'h2: count8 = t.t6;
            default: count8 = t.t8;
        endcase
    endfunction

    function automatic logic [11:0] addr_low(input int idx);
        case (idx)
            0: addr_low = `ECC_UNIT1_VAL_LOW;
            1: addr_low = `ECC_UNIT2_VAL_LOW;
            default: addr_low = `ECC_UNIT3_VAL_LOW;
        endcase
    endfunction

    function automatic logic [11:0] addr_high(input int idx);
        case (idx)
            0: addr_high = `ECC_UNIT1_VAL_HIGH;
            1: addr_high = `ECC_UNIT2_VAL_HIGH;
            default: addr_high = `ECC_UNIT3_VAL_HIGH;
        endcase
    endfunction

    function automatic logic [11:0] addr_ctrl(input int idx);
        case (idx)
            0: addr_ctrl = `ECC_UNIT1_CONTROL;
            1: addr_ctrl = `ECC_UNIT2_CONTROL;
            default: addr_ctrl = `ECC_UNIT3_CONTROL;
        endcase
    endfunction

    // ============================================================
    // state
    ecc_state_t st;
    ecc_state_t next_st;

    always_comb begin
        ecc_unit_t   nu;
        logic [3:0]  m;
        logic [1:0]  code;
        logic [15:0] c16;
        logic [7:0]  c8;
        logic        rise;
        logic        fall;
        logic        is_cap;
        logic        cap_ev;
        logic        match;
        logic        mevt;
        logic        entering;
        logic        set_flag;
        logic        lvl;
        logic [9:0]  duty;
        logic [3:0]  raw;
        logic [3:0]  pol;
        nu = '0;
        m = 4'h0;
        code = 2'h0;
        c16 = 16'h0000;
        c8 = 8'h00;
        rise = 1'b0;
        fall = 1'b0;
        is_cap = 1'b0;
        cap_ev = 1'b0;
        match = 1'b0;
        mevt = 1'b0;
        entering = 1'b0;
        set_flag = 1'b0;
        lvl = 1'b0;
        duty = 10'h000;
        raw = 4'h0;
        pol = 4'h0;
        next_st = st;
        next_st.rdata = 8'h00;
        // pulses drop after one cycle unless a match renews them
        next_st.t1_rst = 1'b0;
        next_st.t3_rst = 1'b0;
        next_st.adc_start = 1'b0;

        for (int i = 0; i < 3; i++) begin
            nu = st.u[i];
            m = nu.unit_control[3:0];
            code = timer_code(st.unit_timer_select, i);
            c16 = count16(code, timers_i);
            c8 = count8(code, timers_i);

            // ============================================================
            // edge detection
            // pad level includes our own drive, so port writes show as edges
            nu.sync1 = cap_pin_i[i];
            nu.sync2 = st.u[i].sync1;
            nu.prev = st.u[i].sync2;
            rise = st.u[i].sync2 & ~st.u[i].prev;
            fall = ~st.u[i].sync2 & st.u[i].prev;

            // ============================================================
            // capture
            is_cap = (m >= `ECC_MODE_CAP_BOTH) && (m <= `ECC_MODE_CAP_16TH);
            case (m)
                `ECC_MODE_CAP_BOTH: cap_ev = rise | fall;
                `ECC_MODE_CAP_FALL: cap_ev = fall;
                `ECC_MODE_CAP_RISE: cap_ev = rise;
                `ECC_MODE_CAP_4TH:  cap_ev = rise && (st.u[i].presc[1:0] == `ECC_PRESC_4TH);
                `ECC_MODE_CAP_16TH: cap_ev = rise && (st.u[i].presc == `ECC_PRESC_16TH);
                default: cap_ev = 1'b0;
            endcase
            // count kept across prescale changes, so first capture may come early
            if (!is_cap) begin
                nu.presc = 4'h0;
            end else if (rise) begin
                nu.presc = st.u[i].presc + 4'h1;
            end
            set_flag = 1'b0;

            // ============================================================
            // compare
            match = (c16 == st.u[i].value);
            // act on the first matching cycle only, a held count must not repeat it
            mevt = match & ~st.u[i].match_q;
            nu.match_q = match;
            entering = (m != st.u[i].prev_mode);
            nu.prev_mode = m;
            case (m)
                `ECC_MODE_TOGGLE: begin
                    if (mevt) begin
                        nu.cmp_latch = ~st.u[i].cmp_latch;
                    end
                end
                `ECC_MODE_CMP_SET: begin
                    if (entering) begin
                        nu.cmp_latch = 1'b0;
                    end else if (mevt) begin
                        nu.cmp_latch = 1'b1;
                        set_flag = 1'b1;
                    end
                end
                `ECC_MODE_CMP_CLEAR: begin
                    if (entering) begin
                        nu.cmp_latch = 1'b1;
                    end else if (mevt) begin
                        nu.cmp_latch = 1'b0;
                        set_flag = 1'b1;
                    end
                end
                `ECC_MODE_CMP_SWI: begin
                    set_flag = mevt;
                end
                `ECC_MODE_CMP_SPECIAL: begin
                    if (mevt) begin
                        set_flag = 1'b1;
                        next_st.adc_start = 1'b1;
                        if (code == 2'h0) begin
                            next_st.t1_rst = 1'b1;
                        end else begin
                            next_st.t3_rst = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase

            // ============================================================
            // value pair
            // capture wins over a same-cycle software write of the value pair
            if (cap_ev) begin
                nu.value = c16;
                set_flag = 1'b1;
            end else if (wr_i && addr_i == addr_low(i)) begin
                nu.value[7:0] = wdata_i;
            end else if (wr_i && addr_i == addr_high(i)) begin
                nu.value[15:8] = wdata_i;
            end

            // ============================================================
            // pins
            nu.pout = 4'h0;
            nu.poe = 4'h0;
            if (m[3:2] == `ECC_MODE_PWM_TOP) begin
                duty = {st.u[i].value[7:0], st.u[i].unit_control[5:4]};
                lvl = ({c8, 2'b00} < duty);
                pol = {m[0], m[1], m[0], m[1]};
                case (st.u[i].unit_control[7:6])
                    `ECC_CFG_FORWARD: begin
                        raw = {lvl, 1'b0, 1'b0, 1'b1};
                        nu.poe = 4'hf;
                    end
                    `ECC_CFG_HALF: begin
                        raw = {1'b0, 1'b0, ~lvl, lvl};
                        nu.poe = 4'h3;
                    end
                    `ECC_CFG_REVERSE: begin
                        raw = {1'b0, 1'b1, lvl, 1'b0};
                        nu.poe = 4'hf;
                    end
                    default: begin
                        // steering not modelled: all four carry the waveform
                        raw = {lvl, lvl, lvl, lvl};
                        nu.poe = 4'hf;
                    end
                endcase
                nu.pout = raw ^ pol;
            end else if (m == `ECC_MODE_TOGGLE || m == `ECC_MODE_CMP_SET ||
                         m == `ECC_MODE_CMP_CLEAR || m == `ECC_MODE_CMP_SPECIAL) begin
                nu.pout = {3'b000, nu.cmp_latch};
                nu.poe = 4'h1;
            end

            // ============================================================
            // unit off
            // value pair and flag survive; only a reset or a software write changes them
            if (m == `ECC_MODE_OFF) begin
                nu.presc = 4'h0;
                nu.cmp_latch = 1'b0;
                nu.match_q = 1'b0;
                nu.pout = 4'h0;
                nu.poe = 4'h0;
            end

            // ============================================================
            // flag
            // set beats a same-cycle clear; only software clears
            nu.unit_irq_flag = (st.u[i].unit_irq_flag &
                                ~(wr_i && addr_i == `ECC_IRQ_FLAGS && wdata_i[i])) |
                               set_flag;

            // ============================================================
            // control writes
            if (wr_i && addr_i == addr_ctrl(i)) begin
                nu.unit_control = wdata_i;
            end
            next_st.u[i] = nu;
        end

        // ============================================================
        // timer selection
        if (wr_i && addr_i == `ECC_TIMER_SELECT) begin
            next_st.unit_timer_select = wdata_i;
        end

        // ============================================================
        // reads
        // read data lasts one cycle, then drops back to zero
        if (rd_i) begin
            case (addr_i)
                `ECC_UNIT1_CONTROL:  next_st.rdata = st.u[0].unit_control;
                `ECC_UNIT2_CONTROL:  next_st.rdata = st.u[1].unit_control;
                `ECC_UNIT3_CONTROL:  next_st.rdata = st.u[2].unit_control;
                `ECC_TIMER_SELECT:   next_st.rdata = st.unit_timer_select;
                `ECC_UNIT1_VAL_LOW:  next_st.rdata = st.u[0].value[7:0];
                `ECC_UNIT1_VAL_HIGH: next_st.rdata = st.u[0].value[15:8];
                `ECC_UNIT2_VAL_LOW:  next_st.rdata = st.u[1].value[7:0];
                `ECC_UNIT2_VAL_HIGH: next_st.rdata = st.u[1].value[15:8];
                `ECC_UNIT3_VAL_LOW:  next_st.rdata = st.u[2].value[7:0];
                `ECC_UNIT3_VAL_HIGH: next_st.rdata = st.u[2].value[15:8];
                `ECC_IRQ_FLAGS: begin
                    next_st.rdata = {5'b00000, st.u[2].unit_irq_flag,
                                     st.u[1].unit_irq_flag, st.u[0].unit_irq_flag};
                end
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    // ============================================================
    // registers
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ============================================================
    // outputs
    // every output is a state bit, so no logic sits after the flops
    assign rdata_o = st.rdata;
    assign timer_one_reset_o = st.t1_rst;
    assign timer_three_reset_o = st.t3_rst;
    assign adc_start_o = st.adc_start;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pwm_out_o[i] = st.u[i].pout;
            pwm_oe_o[i] = st.u[i].poe;
            unit_irq_flag_o[i] = st.u[i].unit_irq_flag;
        end
    end

endmodule

// [ecc_ctrl_asserts.sv]
// concurrent checks on the ports of ecc_ctrl
// assumes one clock domain and the register map of ecc_consts.svh
`timescale 1ns/100ps
`include "ecc_consts.svh"

module ecc_ctrl_asserts (
    input wire logic            sys_clk_i,
    input wire logic            rst_i,
    input wire logic [11:0]     addr_i,
    input wire logic [7:0]      wdata_i,
    input wire logic            wr_i,
    input wire logic [2:0]      cap_pin_i,
    input wire logic [2:0][3:0] pwm_oe_o,
    input wire logic [2:0]      unit_irq_flag_o,
    input wire logic            timer_one_reset_o,
    input wire logic            timer_three_reset_o,
    input wire logic            adc_start_o
);
    // ============================================================
    // shadow of the mode fields; outputs lag one edge behind it
    localparam logic [2:0][11:0] ctl_adr = {`ECC_UNIT3_CONTROL, `ECC_UNIT2_CONTROL,
                                            `ECC_UNIT1_CONTROL};
    logic [2:0][3:0] mode;
    logic [2:0][3:0] mode_q;
    logic [2:0]      side_bad;
    logic [2:0]      clr;

    assign clr = (wr_i && addr_i == `ECC_IRQ_FLAGS) ? wdata_i[2:0] : 3'h0;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode   <= '0;
            mode_q <= '0;
        end else begin
            mode_q <= mode;
            for (int i = 0; i < 3; i++) begin
                if (wr_i && addr_i == ctl_adr[i]) begin
                    mode[i] <= wdata_i[3:0];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            side_bad[i] = mode[i][3:2] != 2'h3 && mode_q[i][3:2] != 2'h3 &&
                          pwm_oe_o[i][3:1] != 3'h0;
        end
    end

    // ============================================================
    // properties
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    a_side_pins_port: assert property (side_bad == 3'h0)
        else $error("side outputs driven outside pwm");
    a_off_quiet: assert property (mode[0] == 4'h0 && mode_q[0] == 4'h0 |->
        pwm_oe_o[0] == 4'h0)
        else $error("unit drives pin while off");
    a_flag_sticky: assert property (
        ((($past(unit_irq_flag_o) & ~unit_irq_flag_o) & ~$past(clr)) == 3'h0))
        else $error("flag dropped without a clear write");
    a_capture_edge: assert property ($rose(unit_irq_flag_o[0]) && mode[0][3:2] == 2'h1
        |-> $past(cap_pin_i[0], 3) != $past(cap_pin_i[0], 4))
        else $error("capture flag without a pin edge");
    a_rise_only: assert property ($rose(unit_irq_flag_o[0]) && mode[0] == 4'h5
        |-> $past(cap_pin_i[0], 3) && !$past(cap_pin_i[0], 4))
        else $error("rising capture on wrong edge");
    a_fall_only: assert property ($rose(unit_irq_flag_o[0]) && mode[0] == 4'h4
        |-> !$past(cap_pin_i[0], 3) && $past(cap_pin_i[0], 4))
        else $error("falling capture on wrong edge");
    a_pulse_single: assert property (timer_one_reset_o |=> !timer_one_reset_o)
        else $error("timer reset pulse too long");
    a_adc_pairs: assert property (adc_start_o |-> timer_one_reset_o || timer_three_reset_o)
        else $error("converter start without timer reset");
endmodule

// [ecc_far_model.sv]
// far side: pad levels passed straight through, and the shared timers
// assumes timers tick once per system clock, never asynchronously
`timescale 1ns/100ps

module ecc_far_model
    import ecc_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] pad_i,
    input  wire logic       timer_one_reset_i,
    input  wire logic       timer_three_reset_i,
    output logic [2:0]      cap_pin_o,
    output ecc_timers_t     timers_o
);
    // ============================================================
    // timers; distinct steps so a wrong selection shows
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            timers_o <= {16'h0000, 16'h8000, 32'h0};
        end else begin
            timers_o.timer_one_count <= timer_one_reset_i ? 16'h0000 :
                timers_o.timer_one_count + 16'h0001;
            timers_o.timer_three_count <= timer_three_reset_i ? 16'h0000 :
                timers_o.timer_three_count + 16'h0003;
            timers_o.t2 <= timers_o.t2 + 8'h01;
            timers_o.t4 <= timers_o.t4 + 8'h02;
            timers_o.t6 <= timers_o.t6 + 8'h03;
            timers_o.t8 <= timers_o.t8 + 8'h05;
        end
    end

    // pads reach the unit unchanged, port writes included
    assign cap_pin_o = pad_i;
endmodule

// [ecc_pkg.sv]
// types for the enhanced capture unit control block
// assumes ecc_consts.svh holds every numeric constant
package ecc_pkg;

    // ============================================================
    // timer inputs
    typedef struct packed {
        logic [15:0] timer_one_count;
        logic [15:0] timer_three_count;
        logic [7:0]  t2;
        logic [7:0]  t4;
        logic [7:0]  t6;
        logic [7:0]  t8;
    } ecc_timers_t;

    // ============================================================
    // per-unit state
    typedef struct packed {
        logic [7:0]  unit_control;
        logic [15:0] value;
        logic        unit_irq_flag;
        logic [3:0]  presc;
        logic        sync1;
        logic        sync2;
        logic        prev;
        logic        match_q;
        logic        cmp_latch;
        logic [3:0]  prev_mode;
        logic [3:0]  pout;
        logic [3:0]  poe;
    } ecc_unit_t;

    typedef struct packed {
        ecc_unit_t [2:0] u;
        logic [7:0]      unit_timer_select;
        logic [7:0]      rdata;
        logic            t1_rst;
        logic            t3_rst;
        logic            adc_start;
    } ecc_state_t;

endpackage

// [tb_top.sv]
// self-checking bench for ecc_ctrl beside the far side model
// assumes a 125 MHz clock and the register map of ecc_consts.svh
`timescale 1ns/100ps
`include "ecc_consts.svh"

module tb_top import ecc_pkg::*;;
    logic            sys_clk_i = 1'b0;
    logic            rst_i = 1'b1;
    logic [11:0]     addr_i = 12'h000;
    logic [7:0]      wdata_i = 8'h00;
    logic            wr_i = 1'b0;
    logic            rd_i = 1'b0;
    logic [2:0]      pad = 3'h0;
    logic [7:0]      rdata_o;
    logic [2:0]      cap_pin_i;
    ecc_timers_t     timers_i;
    logic [2:0][3:0] pwm_out_o;
    logic [2:0][3:0] pwm_oe_o;
    logic [2:0]      flg;
    logic            trst1;
    logic            trst3;
    logic            adc;
    int              n_mismatch = 0;
    int              cmp_count = 0;
    int              n_adc = 0;
    int              n_trst = 0;

    always #4 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        n_adc <= n_adc + int'(adc);
        n_trst <= n_trst + int'(trst1) + 2 * int'(trst3);
    end

    ecc_ctrl dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cap_pin_i(cap_pin_i),
        .timers_i(timers_i), .pwm_out_o(pwm_out_o), .pwm_oe_o(pwm_oe_o),
        .unit_irq_flag_o(flg), .timer_one_reset_o(trst1),
        .timer_three_reset_o(trst3), .adc_start_o(adc));
    ecc_far_model far (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .pad_i(pad), .timer_one_reset_i(trst1),
        .timer_three_reset_i(trst3), .cap_pin_o(cap_pin_i), .timers_o(timers_i));

    // ============================================================
    // bus and pin helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    function automatic logic [11:0] ctl(input int u);
        return u == 0 ? `ECC_UNIT1_CONTROL : (u == 1 ? `ECC_UNIT2_CONTROL : `ECC_UNIT3_CONTROL);
    endfunction
    task automatic clr();
        wr(`ECC_IRQ_FLAGS, 8'h07);
    endtask
    task automatic pin(input int u, input logic lvl);
        @(posedge sys_clk_i);
        pad[u] <= lvl;
        repeat (4) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic cap_once(input int u, input logic lvl);
        logic [15:0] ev;
        logic [7:0]  lo;
        logic [7:0]  hi;
        @(posedge sys_clk_i);
        pad[u] <= lvl;
        repeat (2) @(posedge sys_clk_i);
        #1 ev = u != 0 ? timers_i.timer_three_count : timers_i.timer_one_count;
        repeat (2) @(posedge sys_clk_i);
        rd(`ECC_UNIT1_VAL_LOW + 12'(2 * u), lo);
        rd(`ECC_UNIT1_VAL_HIGH + 12'(2 * u), hi);
        chk({hi, lo}, ev);
        chk(16'(flg[u]), 16'h0001);
    endtask

    // ============================================================
    // scenarios
    task automatic t_regs();
        logic [7:0]  d;
        logic [11:0] ad [5] = '{`ECC_UNIT1_CONTROL, `ECC_UNIT2_CONTROL,
                                `ECC_UNIT3_CONTROL, `ECC_TIMER_SELECT, 12'h000};
        for (int i = 0; i < 5; i++) begin
            rd(ad[i], d);
            chk(16'(d), 16'h0000);
            wr(ad[i], 8'h3a);
            rd(ad[i], d);
            chk(16'(d), i < 4 ? 16'h003a : 16'h0000);
            wr(ad[i], 8'h00);
        end
    endtask
    task automatic t_capture();
        wr(`ECC_TIMER_SELECT, 8'h88);
        for (int u = 0; u < 3; u++) begin
            wr(ctl(u), 8'h35);
            clr();
            cap_once(u, 1'b1);
            clr();
            pin(u, 1'b0);
            chk(16'(flg[u]), 16'h0000);
            wr(ctl(u), 8'h04);
            clr();
            pin(u, 1'b1);
            chk(16'(flg[u]), 16'h0000);
            cap_once(u, 1'b0);
            pin(u, 1'b1);
            cap_once(u, 1'b0);
            wr(ctl(u), 8'h03);
            cap_once(u, 1'b1);
            cap_once(u, 1'b0);
            wr(ctl(u), 8'h00);
        end
    endtask
    task automatic t_prescale();
        wr(ctl(0), 8'h06);
        clr();
        for (int i = 1; i < 23; i++) begin
            if (i == 7) begin
                wr(ctl(0), 8'h00);
                wr(ctl(0), 8'h07);
                clr();
            end
            pin(0, 1'b1);
            pin(0, 1'b0);
            if (i < 5 || i > 6) begin
                chk(16'(flg[0]), 16'(i == 4 || i == 22));
            end
        end
        wr(ctl(0), 8'h00);
    endtask
    task automatic t_compare();
        logic [3:0]  md [5] = '{4'h2, 4'h8, 4'h9, 4'ha, 4'hb};
        logic [15:0] c;
        int          k;
        int          a0;
        int          t0;
        for (int i = 0; i < 5; i++) begin
            clr();
            #1 c = timers_i.timer_one_count + 16'h003c;
            wr(`ECC_UNIT1_VAL_LOW, c[7:0]);
            wr(`ECC_UNIT1_VAL_HIGH, c[15:8]);
            wr(ctl(0), {4'h0, md[i]});
            repeat (2) @(posedge sys_clk_i);
            #1 a0 = n_adc;
            t0 = n_trst;
            if (i < 3) begin
                chk(16'(pwm_out_o[0][0]), 16'(md[i] == 4'h9));
            end
            for (k = 0; k < 200 && (i == 0 ? pwm_out_o[0][0] : flg[0]) !== 1'b1; k++) begin
                @(posedge sys_clk_i);
                #1;
            end
            if (k == 200) begin
                n_mismatch++;
                give_verdict();
            end
            repeat (2) @(posedge sys_clk_i);
            #1;
            if (i < 4) begin
                chk(16'(pwm_oe_o[0][0]), 16'(i < 3));
                chk(16'(pwm_out_o[0][0] & pwm_oe_o[0][0]), 16'(i < 3 && i != 2));
            end else begin
                chk(16'(n_adc - a0), 16'h0001);
                chk(16'(n_trst - t0), 16'h0001);
                chk(16'(timers_i.timer_one_count < 16'h0010), 16'h0001);
            end
            wr(ctl(0), 8'h00);
        end
    endtask
    task automatic t_pwm();
        logic [3:0] eo [4] = '{4'hf, 4'h9, 4'h1, 4'h6};
        logic [3:0] ee [4] = '{4'hf, 4'hf, 4'h3, 4'hf};
        for (int i = 0; i < 9; i++) begin
            wr(`ECC_UNIT1_VAL_LOW, i < 8 ? 8'hff : 8'h00);
            wr(ctl(0), i < 4 ? {2'(i), 6'h3c} : (i < 8 ? {6'h0f, 2'(i)} : 8'h0c));
            repeat (260) @(posedge sys_clk_i);
            #1;
            if (i < 4) begin
                chk(16'(pwm_out_o[0] & pwm_oe_o[0]), 16'(eo[i]));
                chk(16'(pwm_oe_o[0]), 16'(ee[i]));
            end else begin
                chk(16'(pwm_out_o[0]),
                    16'(i < 8 ? 4'hf ^ {i[0], i[1], i[0], i[1]} : 4'h0));
            end
        end
        wr(ctl(0), 8'h00);
        repeat (2) @(posedge sys_clk_i);
        #1 chk(16'(pwm_oe_o[0]), 16'h0000);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_capture();
        t_prescale();
        t_compare();
        t_pwm();
        give_verdict();
    end
endmodule

bind ecc_ctrl ecc_ctrl_asserts u_chk (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .cap_pin_i(cap_pin_i), .pwm_oe_o(pwm_oe_o),
    .unit_irq_flag_o(unit_irq_flag_o), .timer_one_reset_o(timer_one_reset_o),
    .timer_three_reset_o(timer_three_reset_o), .adc_start_o(adc_start_o));
